//--- design/arc_pkg.sv
// Register map, reset values and field layout of the result calibration block
package arc_pkg;
  // Register byte addresses
  localparam logic [31:0] ARC_ADDR_REPEAT = 32'h400c_21f0;
  localparam logic [31:0] ARC_ADDR_LOCK = 32'h400c_2230;
  localparam logic [31:0] ARC_ADDR_LP0_OFFSET = 32'h400c_2288;
  localparam logic [31:0] ARC_ADDR_LP0_GAIN = 32'h400c_228c;
  localparam logic [31:0] ARC_ADDR_LP1_OFFSET = 32'h400c_22c0;
  localparam logic [31:0] ARC_ADDR_LP1_GAIN = 32'h400c_22c4;
  localparam logic [31:0] ARC_ADDR_BUF_CHOP = 32'h400c_238c;
  localparam logic [31:0] ARC_ADDR_REF_CTRL = 32'h400c_2390;
  // Reset values and constant read patterns
  localparam logic [31:0] ARC_REPEAT_RESET = 32'h0000_0160;
  localparam logic [31:0] ARC_BUF_RESET = 32'h005f_3d00;
  localparam logic [31:0] ARC_LOCK_RESET = 32'h0000_0000;
  localparam logic [31:0] ARC_LOCK_KEY = 32'hde87_a5af;
  localparam logic [1:0] ARC_REF_RESET = 2'h3;
  localparam logic [3:0] ARC_CHOP_RESET = 4'h0;
  localparam logic [14:0] ARC_OFFSET_RESET = 15'h0000;
  localparam logic [14:0] ARC_GAIN_RESET = 15'h4000;
  localparam logic [14:0] ARC_GAIN_HALF = 15'h2000;
  localparam logic [14:0] ARC_GAIN_ZERO = 15'h0000;
  // Field positions and widths
  localparam int ARC_CAL_W = 15;
  localparam int ARC_CHOP_W = 4;
  localparam int ARC_REPEAT_EN_BIT = 0;
  localparam int ARC_REPEAT_NUM_BIT = 4;
  localparam int ARC_REF_ILIMIT_BIT = 1;
  localparam int ARC_REF_HPBUF_BIT = 0;
  // Gain is scaled by 2^14, offset carries two fraction bits
  localparam int ARC_GAIN_SHIFT = 14;
  localparam int ARC_FRAC_BITS = 2;
endpackage

//--- design/arc_corrector.sv
// Offset, gain and saturation stage for one converter result
`timescale 1ns/10ps
`default_nettype none
module arc_corrector #(
  parameter int RESULT_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Raw result with its coefficient set
  input wire logic in_valid,
  input wire logic in_chan,
  input wire logic [RESULT_W-1:0] in_result,
  input wire logic [arc_pkg::ARC_CAL_W-1:0] offset,
  input wire logic [arc_pkg::ARC_CAL_W-1:0] gain,
  // Corrected result
  output logic out_valid,
  output logic out_chan,
  output logic [RESULT_W-1:0] out_result
);
  localparam int SUM_W = RESULT_W + 4;
  localparam int PROD_W = SUM_W + 16;
  localparam int DROP = arc_pkg::ARC_GAIN_SHIFT + arc_pkg::ARC_FRAC_BITS;

  // RULE3: raw result moved to quarter steps
  wire logic signed [SUM_W-1:0] raw_q = SUM_W'(signed'({1'b0, in_result, 2'b00}));
  // RULE4: RULE5: offset sign extended
  wire logic signed [SUM_W-1:0] off_ext = SUM_W'(signed'(offset));
  // RULE22: offset first
  wire logic signed [SUM_W-1:0] sum = raw_q + off_ext;
  // RULE8: RULE9: gain over unity code
  wire logic signed [PROD_W-1:0] gain_ext = PROD_W'(signed'({1'b0, gain}));
  wire logic signed [PROD_W-1:0] prod = PROD_W'(sum) * gain_ext;
  wire logic signed [PROD_W-1:0] scaled = prod >>> DROP;
  // RULE22: saturate to word range
  wire logic neg = scaled[PROD_W-1];
  wire logic over = ~neg & (|scaled[PROD_W-2:RESULT_W]);
  wire logic [RESULT_W-1:0] next_result =
    neg ? '0 : (over ? '1 : scaled[RESULT_W-1:0]);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_chan <= 1'b0;
      out_result <= '0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_chan <= in_chan;
        out_result <= next_result;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_gain_zero;
    in_valid && gain == arc_pkg::ARC_GAIN_ZERO |=> out_valid && out_result == '0;
  endproperty
  a_gain_zero: assert property (p_gain_zero) else $error("zero gain gave nonzero"); // RULE11

  property p_identity;
    in_valid && offset == arc_pkg::ARC_OFFSET_RESET && gain == arc_pkg::ARC_GAIN_RESET
      |=> out_result == $past(in_result);
  endproperty
  a_identity: assert property (p_identity) else $error("unity set changed result"); // RULE6 RULE8

  property p_half;
    in_valid && offset == arc_pkg::ARC_OFFSET_RESET && gain == arc_pkg::ARC_GAIN_HALF
      |=> out_result == ($past(in_result) >> 1);
  endproperty
  a_half: assert property (p_half) else $error("half gain not halving"); // RULE10
endmodule
`default_nettype wire

//--- design/arc_calibration.sv
// Result calibration block with Avalon-MM register slave and analog controls
//
// Notes on behaviour
// RULE1: Channel 0 offset word in bits 14:0
// RULE2: Channel 1 has its own offset word
// RULE3: Offset twos complement, quarter LSB steps
// RULE4: 0x3FFF is +4095.75, 0x0001 is +0.25
// RULE5: 0x7FFF is -0.25, 0x4000 is -4096
// RULE6: Zero offset leaves result; resets zero
// RULE7: Channel 0 gain word, resets to unity
// RULE8: Factor equals gain divided by 0x4000
// RULE9: 0x7FFF near two, linear steps
// RULE10: Gain 0x2000 halves the result
// RULE11: Gain zero forces a zero result
// RULE12: Calibration words accessible only with password
// RULE13: Writes ignored while locked; lock resets zero
// RULE14: Repeat bit 0 enables repeat conversions
// RULE15: Repeat bit 4 reads zero, read-only
// RULE16: Bits 3,2 disable buffer chopping
// RULE17: Bits 1,0 disable amplifier, front chopping
// RULE18: Software picks recommended buffer values
// RULE19: Reference bit 1 drives current limit
// RULE20: Reference bit 0 drives reference buffer
// RULE21: Channel 1 gain word, resets unity
// RULE22: Add offset, multiply gain, then saturate
// RULE23: Coefficients chosen by incoming channel identity
`timescale 1ns/10ps
`default_nettype none
module arc_calibration #(
  parameter int RESULT_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Raw results from the converter front end
  input wire logic raw_valid,
  input wire logic raw_chan,
  input wire logic [RESULT_W-1:0] raw_result,
  // Corrected results
  output logic corr_valid,
  output logic corr_chan,
  output logic [RESULT_W-1:0] corr_result,
  // Analog controls
  output logic repeat_conv_en,
  output logic [arc_pkg::ARC_CHOP_W-1:0] chop_disable,
  output logic input_buffer_current_limit_en,
  output logic high_power_ref_buffer_en
);
  localparam int CW = arc_pkg::ARC_CAL_W;

  // Byte lane merge of a write into an old word
  function automatic logic [31:0] arc_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] lanes
  );
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        res[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Register storage
  logic [31:0] cal_lock;
  logic [CW-1:0] lp0_offset;
  logic [CW-1:0] lp0_gain;
  logic [CW-1:0] lp1_offset;
  logic [CW-1:0] lp1_gain;
  logic [1:0] ref_ctrl;
  logic bus_done;

  // Address decode
  wire logic sel_repeat = avs_address == arc_pkg::ARC_ADDR_REPEAT;
  wire logic sel_lock = avs_address == arc_pkg::ARC_ADDR_LOCK;
  wire logic sel_off0 = avs_address == arc_pkg::ARC_ADDR_LP0_OFFSET;
  wire logic sel_gain0 = avs_address == arc_pkg::ARC_ADDR_LP0_GAIN;
  wire logic sel_off1 = avs_address == arc_pkg::ARC_ADDR_LP1_OFFSET;
  wire logic sel_gain1 = avs_address == arc_pkg::ARC_ADDR_LP1_GAIN;
  wire logic sel_buf = avs_address == arc_pkg::ARC_ADDR_BUF_CHOP;
  wire logic sel_ref = avs_address == arc_pkg::ARC_ADDR_REF_CTRL;
  wire logic sel_cal = sel_off0 | sel_gain0 | sel_off1 | sel_gain1;

  // Every access answers on its second cycle
  wire logic bus_req = avs_read | avs_write;
  wire logic next_bus_done = bus_req & ~bus_done;
  assign avs_waitrequest = bus_req & ~bus_done;
  wire logic wr_ok = avs_write & bus_done;
  wire logic rd_load = avs_read & ~bus_done;

  // RULE12: password opens calibration words
  wire logic unlocked = cal_lock == arc_pkg::ARC_LOCK_KEY;
  // RULE13: locked writes dropped
  wire logic cal_wr = wr_ok & unlocked;

  // Merged write words
  wire logic [31:0] wr_lock = arc_merge(cal_lock, avs_writedata, avs_byteenable);
  wire logic [31:0] wr_off0 =
    arc_merge({17'h0_0000, lp0_offset}, avs_writedata, avs_byteenable);
  wire logic [31:0] wr_gain0 =
    arc_merge({17'h0_0000, lp0_gain}, avs_writedata, avs_byteenable);
  wire logic [31:0] wr_off1 =
    arc_merge({17'h0_0000, lp1_offset}, avs_writedata, avs_byteenable);
  wire logic [31:0] wr_gain1 =
    arc_merge({17'h0_0000, lp1_gain}, avs_writedata, avs_byteenable);
  wire logic [31:0] wr_ref =
    arc_merge({30'h0000_0000, ref_ctrl}, avs_writedata, avs_byteenable);
  wire logic wr_lane0 = wr_ok & avs_byteenable[0];

  // Read views
  // RULE15: number bit held at zero
  wire logic [31:0] rd_repeat = arc_pkg::ARC_REPEAT_RESET | {31'h0000_0000, repeat_conv_en};
  wire logic [31:0] rd_buf = arc_pkg::ARC_BUF_RESET | {28'h000_0000, chop_disable};
  wire logic [31:0] rd_off0 = {17'h0_0000, lp0_offset};
  wire logic [31:0] rd_gain0 = {17'h0_0000, lp0_gain};
  wire logic [31:0] rd_off1 = {17'h0_0000, lp1_offset};
  wire logic [31:0] rd_gain1 = {17'h0_0000, lp1_gain};
  wire logic [31:0] rd_cal =
    sel_off0 ? rd_off0 :
    sel_gain0 ? rd_gain0 :
    sel_off1 ? rd_off1 : rd_gain1;
  // RULE12: locked reads show zero
  wire logic [31:0] rd_cal_gated = unlocked ? rd_cal : 32'h0000_0000;
  wire logic [31:0] next_readdata =
    sel_repeat ? rd_repeat :
    sel_lock ? cal_lock :
    sel_cal ? rd_cal_gated :
    sel_buf ? rd_buf :
    sel_ref ? {30'h0000_0000, ref_ctrl} : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bus_done <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_done <= next_bus_done;
      if (rd_load) begin
        avs_readdata <= next_readdata;
      end
    end
  end

  // RULE13: lock resets to zero
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cal_lock <= arc_pkg::ARC_LOCK_RESET;
    end else if (wr_ok && sel_lock) begin
      cal_lock <= wr_lock;
    end
  end

  // RULE1: RULE6: channel 0 offset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lp0_offset <= arc_pkg::ARC_OFFSET_RESET;
    end else if (cal_wr && sel_off0) begin
      lp0_offset <= wr_off0[CW-1:0];
    end
  end

  // RULE7: channel 0 gain
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lp0_gain <= arc_pkg::ARC_GAIN_RESET;
    end else if (cal_wr && sel_gain0) begin
      lp0_gain <= wr_gain0[CW-1:0];
    end
  end

  // RULE2: channel 1 offset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lp1_offset <= arc_pkg::ARC_OFFSET_RESET;
    end else if (cal_wr && sel_off1) begin
      lp1_offset <= wr_off1[CW-1:0];
    end
  end

  // RULE21: channel 1 gain
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lp1_gain <= arc_pkg::ARC_GAIN_RESET;
    end else if (cal_wr && sel_gain1) begin
      lp1_gain <= wr_gain1[CW-1:0];
    end
  end

  // RULE14: repeat conversion enable
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      repeat_conv_en <= arc_pkg::ARC_REPEAT_RESET[arc_pkg::ARC_REPEAT_EN_BIT];
    end else if (wr_lane0 && sel_repeat) begin
      repeat_conv_en <= avs_writedata[arc_pkg::ARC_REPEAT_EN_BIT];
    end
  end

  // RULE16: RULE17: chop disable bits
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      chop_disable <= arc_pkg::ARC_CHOP_RESET;
    end else if (wr_lane0 && sel_buf) begin
      chop_disable <= avs_writedata[arc_pkg::ARC_CHOP_W-1:0];
    end
  end

  // RULE19: RULE20: reference control bits
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ref_ctrl <= arc_pkg::ARC_REF_RESET;
    end else if (wr_ok && sel_ref) begin
      ref_ctrl <= wr_ref[1:0];
    end
  end
  assign input_buffer_current_limit_en = ref_ctrl[arc_pkg::ARC_REF_ILIMIT_BIT];
  assign high_power_ref_buffer_en = ref_ctrl[arc_pkg::ARC_REF_HPBUF_BIT];

  // RULE23: coefficient set by channel
  wire logic [CW-1:0] sel_offset = raw_chan ? lp1_offset : lp0_offset;
  wire logic [CW-1:0] sel_gain = raw_chan ? lp1_gain : lp0_gain;

  arc_corrector #(
    .RESULT_W(RESULT_W)
  ) u_corrector (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(raw_valid),
    .in_chan(raw_chan),
    .in_result(raw_result),
    .offset(sel_offset),
    .gain(sel_gain),
    .out_valid(corr_valid),
    .out_chan(corr_chan),
    .out_result(corr_result)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_bus_answer;
    bus_req |-> ##[0:1] !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus access not answered");

  property p_locked_write;
    wr_ok && sel_cal && !unlocked |=> $stable(lp0_offset) && $stable(lp0_gain)
      && $stable(lp1_offset) && $stable(lp1_gain);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write changed data"); // RULE13

  property p_off0_write;
    wr_ok && sel_off0 && unlocked && avs_byteenable == 4'hf
      |=> lp0_offset == $past(avs_writedata[14:0]);
  endproperty
  a_off0_write: assert property (p_off0_write) else $error("offset 0 not written"); // RULE1

  property p_off1_write;
    wr_ok && sel_off1 && unlocked && avs_byteenable == 4'hf
      |=> lp1_offset == $past(avs_writedata[14:0]) && $stable(lp0_offset);
  endproperty
  a_off1_write: assert property (p_off1_write) else $error("offset 1 not written"); // RULE2

  property p_locked_read;
    rd_load && sel_cal && !unlocked |=> avs_readdata == 32'h0000_0000;
  endproperty
  a_locked_read: assert property (p_locked_read) else $error("locked read not zero"); // RULE12

  property p_num_zero;
    rd_load && sel_repeat |=> !avs_readdata[arc_pkg::ARC_REPEAT_NUM_BIT];
  endproperty
  a_num_zero: assert property (p_num_zero) else $error("number bit not zero"); // RULE15

  property p_repeat;
    wr_lane0 && sel_repeat |=> repeat_conv_en == $past(avs_writedata[0]);
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat enable not written"); // RULE14

  property p_chop;
    wr_lane0 && sel_buf |=> chop_disable == $past(avs_writedata[3:0]);
  endproperty
  a_chop: assert property (p_chop) else $error("chop bits not written"); // RULE16 RULE17

  property p_ref_reset;
    !$past(reset_n) |-> input_buffer_current_limit_en && high_power_ref_buffer_en;
  endproperty
  a_ref_reset: assert property (p_ref_reset) else $error("reference bits not set"); // RULE19 RULE20

  property p_chan_select;
    raw_valid |=> corr_valid && corr_chan == $past(raw_chan);
  endproperty
  a_chan_select: assert property (p_chan_select) else $error("channel not carried"); // RULE23

  property p_lock_write;
    wr_ok && sel_lock && avs_byteenable == 4'hf |=> cal_lock == $past(avs_writedata);
  endproperty
  a_lock_write: assert property (p_lock_write) else $error("lock word not written"); // RULE12

  property p_gain0_write;
    wr_ok && sel_gain0 && unlocked && avs_byteenable == 4'hf
      |=> lp0_gain == $past(avs_writedata[14:0]);
  endproperty
  a_gain0_write: assert property (p_gain0_write) else $error("gain 0 not written"); // RULE7

  property p_gain1_write;
    wr_ok && sel_gain1 && unlocked && avs_byteenable == 4'hf
      |=> lp1_gain == $past(avs_writedata[14:0]) && $stable(lp0_gain);
  endproperty
  a_gain1_write: assert property (p_gain1_write) else $error("gain 1 not written"); // RULE21

  property p_unlocked_read;
    rd_load && sel_off0 && unlocked
      |=> avs_readdata[14:0] == $past(lp0_offset) && avs_readdata[31:15] == 17'h0_0000;
  endproperty
  a_unlocked_read: assert property (p_unlocked_read) else $error("offset 0 read wrong"); // RULE1

  property p_ref_write;
    wr_ok && sel_ref && avs_byteenable[0]
      |=> {input_buffer_current_limit_en, high_power_ref_buffer_en} == $past(avs_writedata[1:0]);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference bits not written"); // RULE19 RULE20

  property p_first_wait;
    $rose(bus_req) |-> avs_waitrequest;
  endproperty
  a_first_wait: assert property (p_first_wait) else $error("access answered without wait");

  property p_readdata_hold;
    !rd_load |=> $stable(avs_readdata);
  endproperty
  a_readdata_hold: assert property (p_readdata_hold) else $error("read data changed idle");

  property p_corr_idle;
    !raw_valid |=> !corr_valid && $stable(corr_result) && $stable(corr_chan);
  endproperty
  a_corr_idle: assert property (p_corr_idle) else $error("result changed without input"); // RULE22
endmodule
`default_nettype wire

//--- verification/arc_fe_model.sv
// Behavioural model of the converter front end delivering raw results
`timescale 1ns/10ps
`default_nettype none
module arc_fe_model (
  // Clock
  input wire logic sys_clk,
  // Raw result stream
  output logic raw_valid,
  output logic raw_chan,
  output logic [15:0] raw_result
);
  initial begin
    raw_valid = 1'b0;
    raw_chan = 1'b0;
    raw_result = 16'h0000;
  end

  // Drives one cycle of the stream; idle cycles scramble the data lines
  task automatic drive(input logic v, input logic c, input logic [15:0] r);
    @(posedge sys_clk);
    raw_valid <= v;
    if (v) begin
      raw_chan <= c;
      raw_result <= r;
    end else begin
      raw_chan <= ~raw_chan;
      raw_result <= ~raw_result;
    end
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking testbench for the result calibration block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_address, avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, chop_disable;
  logic raw_valid, raw_chan, corr_valid, corr_chan;
  logic [15:0] raw_result, corr_result;
  logic repeat_conv_en, input_buffer_current_limit_en, high_power_ref_buffer_en;
  logic [14:0] cur_off [2];
  logic [14:0] cur_gain [2];
  int n_mismatch, n_checks;

  arc_calibration #(.RESULT_W(16)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .raw_valid(raw_valid),
    .raw_chan(raw_chan), .raw_result(raw_result), .corr_valid(corr_valid),
    .corr_chan(corr_chan), .corr_result(corr_result), .repeat_conv_en(repeat_conv_en),
    .chop_disable(chop_disable),
    .input_buffer_current_limit_en(input_buffer_current_limit_en),
    .high_power_ref_buffer_en(high_power_ref_buffer_en));

  arc_fe_model u_fe (.sys_clk(sys_clk), .raw_valid(raw_valid), .raw_chan(raw_chan),
    .raw_result(raw_result));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One Avalon-MM access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) chk(32'h0000_0000, 32'h0000_0001, "bus hang");
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'hf, x);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string s);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, 4'hf, x);
    chk(x, e, s);
  endtask

  function automatic logic [15:0] model(logic [15:0] r, logic [14:0] o, logic [14:0] g);
    longint s;
    s = (longint'(r) * 4 + longint'($signed(o))) * longint'(g);
    s = s >>> 16;
    if (s < 0) return 16'h0000;
    if (s > 65535) return 16'hffff;
    return s[15:0];
  endfunction

  function automatic logic [31:0] pins();
    return {25'd0, repeat_conv_en, chop_disable, input_buffer_current_limit_en,
            high_power_ref_buffer_en};
  endfunction

  // Pins are looked at mid-cycle, after the write edge has settled
  task automatic chk_pins(input logic [31:0] e, input string s);
    @(negedge sys_clk);
    chk(pins(), e, s);
  endtask

  task automatic set_cal(input logic c, input logic [14:0] o, input logic [14:0] g);
    wr(c ? arc_pkg::ARC_ADDR_LP1_OFFSET : arc_pkg::ARC_ADDR_LP0_OFFSET, {17'd0, o});
    wr(c ? arc_pkg::ARC_ADDR_LP1_GAIN : arc_pkg::ARC_ADDR_LP0_GAIN, {17'd0, g});
    cur_off[c] = o;
    cur_gain[c] = g;
  endtask

  task automatic t_reset();
    chk_pins(32'h0000_0003, "pins at reset");
    rdc(arc_pkg::ARC_ADDR_REPEAT, 32'h0000_0160, "repeat reset");
    rdc(arc_pkg::ARC_ADDR_BUF_CHOP, 32'h005f_3d00, "buffer reset");
    rdc(arc_pkg::ARC_ADDR_LOCK, 32'h0000_0000, "lock reset");
    rdc(arc_pkg::ARC_ADDR_REF_CTRL, 32'h0000_0003, "ref reset");
    rdc(arc_pkg::ARC_ADDR_LP0_GAIN, 32'h0000_0000, "locked read");
    rdc(32'h400c_2000, 32'h0000_0000, "unmapped read");
  endtask

  task automatic t_ctrl();
    logic [31:0] x;
    wr(arc_pkg::ARC_ADDR_REPEAT, 32'hffff_ffff);
    rdc(arc_pkg::ARC_ADDR_REPEAT, 32'h0000_0161, "repeat set");
    chk_pins(32'h0000_0043, "repeat pin on");
    wr(arc_pkg::ARC_ADDR_REPEAT, 32'h0000_0000);
    chk_pins(32'h0000_0003, "repeat pin off");
    for (int i = 0; i < 4; i++) begin
      wr(arc_pkg::ARC_ADDR_BUF_CHOP, 32'h005f_3d00 | (32'h0000_0001 << i));
      chk_pins(32'h0000_0003 | (32'h0000_0004 << i), "chop bit");
    end
    bus(1'b1, arc_pkg::ARC_ADDR_BUF_CHOP, 32'hffff_ffff, 4'h1, x);
    rdc(arc_pkg::ARC_ADDR_BUF_CHOP, 32'h005f_3d0f, "chop lane");
    wr(arc_pkg::ARC_ADDR_BUF_CHOP, 32'h005f_3d04);
    wr(arc_pkg::ARC_ADDR_REF_CTRL, 32'h0000_0002);
    chk_pins(32'h0000_0012, "ref bit0 off");
    wr(arc_pkg::ARC_ADDR_REF_CTRL, 32'h0000_0001);
    chk_pins(32'h0000_0011, "ref bit1 off");
    wr(arc_pkg::ARC_ADDR_REF_CTRL, 32'h0000_0003);
  endtask

  task automatic t_lock();
    wr(arc_pkg::ARC_ADDR_LP0_OFFSET, 32'h0000_1234);
    wr(arc_pkg::ARC_ADDR_LOCK, arc_pkg::ARC_LOCK_KEY);
    rdc(arc_pkg::ARC_ADDR_LOCK, 32'hde87_a5af, "lock value");
    rdc(arc_pkg::ARC_ADDR_LP0_OFFSET, 32'h0000_0000, "locked write");
    rdc(arc_pkg::ARC_ADDR_LP1_OFFSET, 32'h0000_0000, "off1 reset");
    rdc(arc_pkg::ARC_ADDR_LP0_GAIN, 32'h0000_4000, "gain0 reset");
    rdc(arc_pkg::ARC_ADDR_LP1_GAIN, 32'h0000_4000, "gain1 reset");
    wr(arc_pkg::ARC_ADDR_LP0_OFFSET, 32'hffff_ffff);
    rdc(arc_pkg::ARC_ADDR_LP0_OFFSET, 32'h0000_7fff, "offset field");
    wr(arc_pkg::ARC_ADDR_LP0_OFFSET, 32'h0000_0000);
    wr(arc_pkg::ARC_ADDR_LOCK, 32'hde87_a5ae);
    wr(arc_pkg::ARC_ADDR_LP0_GAIN, 32'h0000_1111);
    wr(arc_pkg::ARC_ADDR_LOCK, arc_pkg::ARC_LOCK_KEY);
    rdc(arc_pkg::ARC_ADDR_LP0_GAIN, 32'h0000_4000, "near key");
    cur_off = '{15'h0000, 15'h0000};
    cur_gain = '{15'h4000, 15'h4000};
  endtask

  task automatic t_math();
    logic [46:0] tbl [9];
    tbl = '{{1'b0, 15'h0000, 15'h4000, 16'h1234}, {1'b0, 15'h3fff, 15'h4000, 16'h0100},
            {1'b0, 15'h0001, 15'h7fff, 16'h0100}, {1'b1, 15'h7fff, 15'h4000, 16'h0100},
            {1'b1, 15'h4000, 15'h4000, 16'h2000}, {1'b0, 15'h0000, 15'h2000, 16'h1234},
            {1'b1, 15'h0000, 15'h0000, 16'hffff}, {1'b0, 15'h0000, 15'h7fff, 16'hc000},
            {1'b1, 15'h4000, 15'h4000, 16'h0010}};
    foreach (tbl[i]) begin
      set_cal(tbl[i][46], tbl[i][45:31], tbl[i][30:16]);
      u_fe.drive(1'b1, tbl[i][46], tbl[i][15:0]);
      u_fe.drive(1'b0, 1'b0, 16'h0000);
      @(negedge sys_clk);
      chk({corr_valid, corr_chan, corr_result},
          {1'b1, tbl[i][46], model(tbl[i][15:0], tbl[i][45:31], tbl[i][30:16])},
          "table result");
    end
    set_cal(1'b0, 15'h3fff, 15'h2000);
    set_cal(1'b1, 15'h7fff, 15'h7fff);
    u_fe.drive(1'b1, 1'b0, 16'h0800);
    u_fe.drive(1'b1, 1'b1, 16'h0800);
    @(negedge sys_clk);
    chk({corr_valid, corr_chan, corr_result},
        {2'b10, model(16'h0800, cur_off[0], cur_gain[0])}, "chan0 pair");
    u_fe.drive(1'b0, 1'b0, 16'h0000);
    @(negedge sys_clk);
    chk({corr_valid, corr_chan, corr_result},
        {2'b11, model(16'h0800, cur_off[1], cur_gain[1])}, "chan1 pair");
  endtask

  initial begin
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 32'h0000_0000;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_ctrl();
    t_lock();
    t_math();
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
